/* tmthr_defs.vh */
// register map, field layout and reset values of the thermal monitor
`ifndef TMTHR_DEFS_VH
`define TMTHR_DEFS_VH

// byte addresses, low and high word of each 64-bit register
`define TMTHR_SAMPLE_LO       32'h1fe00198
`define TMTHR_SAMPLE_HI       32'h1fe0019c
`define TMTHR_HOT_LO          32'h3ff01460
`define TMTHR_HOT_HI          32'h3ff01464
`define TMTHR_COLD_LO         32'h3ff01468
`define TMTHR_COLD_HI         32'h3ff0146c
`define TMTHR_FLAGS_LO        32'h3ff01470
`define TMTHR_FLAGS_HI        32'h3ff01474
`define TMTHR_MASK_LO         32'h3ff01478
`define TMTHR_MASK_HI         32'h3ff0147c
`define TMTHR_THROT_LO        32'h3ff01480
`define TMTHR_THROT_HI        32'h3ff01484

// sampling word fields
`define TMTHR_OVER_A_BIT      24
`define TMTHR_OVER_B_BIT      25
`define TMTHR_RAW_A_LSB       32
`define TMTHR_RAW_B_LSB       48

// per-group lane layout, lane k starts at bit 16k
`define TMTHR_LANE_W          16
`define TMTHR_THR_LSB         0
`define TMTHR_EN_BIT          8
`define TMTHR_SEL_LSB         10
`define TMTHR_RATIO_LSB       12
`define TMTHR_ALARM_WMASK     16'h0dff
`define TMTHR_THROT_WMASK     16'h7dff

// flag bits
`define TMTHR_HOT_FLAG        0
`define TMTHR_COLD_FLAG       1

// conversion: celsius = raw * 731 / 0x4000 - 273
`define TMTHR_CONV_MUL        10'd731
`define TMTHR_CONV_SHIFT      14
`define TMTHR_CONV_OFFSET     14'sd273
`define TMTHR_OVER_LIMIT      14'sd125

// reset values
`define TMTHR_SETUP_RESET     64'h0000000000000000
`define TMTHR_FLAGS_RESET     2'h0
`define TMTHR_MASK_RESET      2'h3

// throttle: a ratio of eight is full speed
`define TMTHR_RATIO_FULL      4'h8

`endif

/* tmthr_sync.v */
// three-stage synchroniser that accepts a bit once stages two and three agree
`timescale 1ns/1ps

module tmthr_sync #(
    parameter W = 16
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);

    genvar b;

    // one chain per bit; stage one feeds stage two only
    generate
        for (b = 0; b < W; b = b + 1) begin : g_bit
            reg s1;
            reg s2;
            reg s3;
            reg held;

            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1   <= 1'b0;
                    s2   <= 1'b0;
                    s3   <= 1'b0;
                    held <= 1'b0;
                end else begin
                    s1 <= din[b];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        held <= s3; // stable value accepted
                    end
                end
            end

            assign dout[b] = held;
        end
    endgenerate

endmodule

/* tmthr_top.v */
// thermal monitor: sampling word, hot/cold alarms and clock throttling
//
// Functional notes
// R1 - both sensor readings and over-range flags readable in a read-only word
// R2 - sensor a over-range flag set while its temperature exceeds 125 C
// R3 - sensor b over-range flag sits in bit 25 of the sampling word
// R4 - celsius equals raw times 731 over 0x4000 minus 273
// R5 - four hot and four cold alarm groups, each threshold, enable, select
// R6 - group k lane: threshold bits 16k+7..16k, enable bit 16k+8
// R7 - enabled hot group above its threshold raises the hot interrupt
// R8 - enabled cold group below its threshold raises the cold interrupt
// R9 - select bits 16k+11..16k+10 pick sensor: 0 is a, 1 is b
// R10 - hot event latched in flag bit 0, cold event in bit 1
// R11 - any write to the flag register clears the latched flags
// R12 - four throttle groups: threshold, enable, select and divide ratio
// R13 - throttle ratio sits in bits 16k+14..16k+12 of lane k
// R14 - throttle group acts only when enabled and temperature above threshold
// R15 - triggered throttle runs the clock at ratio over eight; the code runs a ratio of zero at full speed
// R16 - group 0 has highest throttle priority, group 3 lowest
// R17 - one level interrupt output while an unmasked latched flag is set
// R18 - no triggered throttle group means the clock runs undivided
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "tmthr_defs.vh"

module tmthr_top #(
    parameter RAW_W = 16,
    parameter NGRP  = 4
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [31:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire [15:0] sensor_a_raw_reading,
    input  wire [15:0] sensor_b_raw_reading,
    output wire        thermal_irq,
    output reg         throttle_active,
    output reg  [2:0]  throttle_ratio,
    output reg         core_clk_enable
);

    // ========
    // declarations
    // ========
    reg  [63:0]       hot_alarm_setup;
    reg  [63:0]       cold_alarm_setup;
    reg  [63:0]       clock_throttle_setup;
    reg  [1:0]        thermal_alarm_flags;
    reg  [1:0]        alarm_mask;
    reg               bus_ack;
    reg  [2:0]        div_acc;

    wire [RAW_W-1:0]  raw_a;
    wire [RAW_W-1:0]  raw_b;
    wire [25:0]       prod_a;
    wire [25:0]       prod_b;
    wire signed [13:0] cel_a;
    wire signed [13:0] cel_b;
    wire              sensor_a_over_range;
    wire              sensor_b_over_range;
    wire [63:0]       temp_sample_word;

    wire [NGRP-1:0]   hot_hit;
    wire [NGRP-1:0]   cold_hit;
    wire [NGRP-1:0]   thr_hit;
    wire [3*NGRP-1:0] thr_ratio;

    wire              bus_req;
    wire              wr_go;
    wire              flags_clear;
    wire [1:0]        flag_events;

    reg  [2:0]        next_ratio;
    reg               next_active;
    reg  [31:0]       next_readdata;
    reg  [3:0]        eff_ratio;
    reg  [3:0]        acc_sum;
    integer           p;

    // byte-lane merge limited to the writable bits
    function [31:0] tmthr_merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0]  be;
        input [31:0] wmask;
        integer i;
        begin
            tmthr_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    tmthr_merge[8*i +: 8] = wd[8*i +: 8];
                end
            end
            tmthr_merge = tmthr_merge & wmask;
        end
    endfunction

    // ========
    // sensor capture and conversion
    // ========
    // sensor words come from the analog side, so they are synchronised
    tmthr_sync #(
        .W    (RAW_W)
    ) u_sync_a (
        .clk  (clk),
        .rst  (rst),
        .din  (sensor_a_raw_reading),
        .dout (raw_a)
    );

    tmthr_sync #(
        .W    (RAW_W)
    ) u_sync_b (
        .clk  (clk),
        .rst  (rst),
        .din  (sensor_b_raw_reading),
        .dout (raw_b)
    );

    // raw to celsius, kept signed so cold thresholds below zero work
    assign prod_a = raw_a * `TMTHR_CONV_MUL; // [R4]
    assign prod_b = raw_b * `TMTHR_CONV_MUL; // [R4]
    assign cel_a  = $signed({2'b00, prod_a[25:`TMTHR_CONV_SHIFT]})
                    - `TMTHR_CONV_OFFSET; // [R4]
    assign cel_b  = $signed({2'b00, prod_b[25:`TMTHR_CONV_SHIFT]})
                    - `TMTHR_CONV_OFFSET; // [R4]

    // over-range flags follow the converted temperature
    assign sensor_a_over_range = (cel_a > `TMTHR_OVER_LIMIT); // [R2]
    assign sensor_b_over_range = (cel_b > `TMTHR_OVER_LIMIT);

    // read-only sampling word, unused bits read as zero
    assign temp_sample_word = {raw_b, raw_a, 6'h00,
                               sensor_b_over_range, // [R3]
                               sensor_a_over_range,
                               24'h000000}; // [R1]

    // ========
    // alarm and throttle groups
    // ========
    genvar g;

    generate
        for (g = 0; g < NGRP; g = g + 1) begin : g_grp
            wire [7:0]         hot_thr;
            wire               hot_on;
            wire [1:0]         hot_src;
            wire [7:0]         cold_thr;
            wire               cold_on;
            wire [1:0]         cold_src;
            wire [7:0]         thr_thr;
            wire               thr_on;
            wire [1:0]         thr_src;
            wire signed [13:0] hot_temp;
            wire signed [13:0] cold_temp;
            wire signed [13:0] thr_temp;
            wire               hot_valid;
            wire               cold_valid;
            wire               thr_valid;

            // lane fields of group g
            assign hot_thr  = hot_alarm_setup[16*g +: 8]; // [R6]
            assign hot_on   = hot_alarm_setup[16*g+`TMTHR_EN_BIT]; // [R6]
            assign hot_src  = hot_alarm_setup[16*g+`TMTHR_SEL_LSB +: 2];
            assign cold_thr = cold_alarm_setup[16*g +: 8]; // [R6]
            assign cold_on  = cold_alarm_setup[16*g+`TMTHR_EN_BIT];
            assign cold_src = cold_alarm_setup[16*g+`TMTHR_SEL_LSB +: 2];
            assign thr_thr  = clock_throttle_setup[16*g +: 8];
            assign thr_on   = clock_throttle_setup[16*g+`TMTHR_EN_BIT];
            assign thr_src  =
                clock_throttle_setup[16*g+`TMTHR_SEL_LSB +: 2];
            assign thr_ratio[3*g +: 3] =
                clock_throttle_setup[16*g+`TMTHR_RATIO_LSB +: 3]; // [R13]

            // source select; codes 2 and 3 leave the group inert
            assign hot_temp   = hot_src[0] ? cel_b : cel_a; // [R9]
            assign cold_temp  = cold_src[0] ? cel_b : cel_a; // [R9]
            assign thr_temp   = thr_src[0] ? cel_b : cel_a; // [R9]
            assign hot_valid  = ~hot_src[1];
            assign cold_valid = ~cold_src[1];
            assign thr_valid  = ~thr_src[1];

            // comparisons against sign-extended thresholds
            assign hot_hit[g]  = hot_on & hot_valid &
                (hot_temp > $signed({{6{hot_thr[7]}}, hot_thr}));  // [R7]
            assign cold_hit[g] = cold_on & cold_valid &
                (cold_temp < $signed({{6{cold_thr[7]}}, cold_thr})); // [R8]
            assign thr_hit[g]  = thr_on & thr_valid &
                (thr_temp > $signed({{6{thr_thr[7]}}, thr_thr})); // [R14]
        end
    endgenerate

    // ========
    // throttle priority and clock divider
    // ========
    // scan from the lowest priority up so group 0 wins
    always @* begin
        next_ratio  = 3'h0;
        next_active = 1'b0;
        for (p = NGRP - 1; p >= 0; p = p - 1) begin
            if (thr_hit[p]) begin
                next_ratio  = thr_ratio[3*p +: 3]; // [R16]
                next_active = 1'b1; // [R16]
            end
        end
    end

    // ratio zero is taken as full speed; no group means undivided
    always @* begin
        if (!throttle_active || throttle_ratio == 3'h0) begin
            eff_ratio = `TMTHR_RATIO_FULL; // [R18]
        end else begin
            eff_ratio = {1'b0, throttle_ratio}; // [R15]
        end
        acc_sum = {1'b0, div_acc} + eff_ratio;
    end

    // selection is registered, then an accumulator passes ratio of 8 edges
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            throttle_active <= 1'b0;
            throttle_ratio  <= 3'h0;
            div_acc         <= 3'h0;
            core_clk_enable <= 1'b1;
        end else begin
            throttle_active <= next_active;
            throttle_ratio  <= next_ratio;
            div_acc         <= acc_sum[2:0];
            core_clk_enable <= acc_sum[3]; // [R15]
        end
    end

    // ========
    // alarm flags and interrupt
    // ========
    assign flag_events = {|cold_hit, |hot_hit}; // [R10]

    // an event in the clearing cycle stays set
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            thermal_alarm_flags <= `TMTHR_FLAGS_RESET;
        end else if (flags_clear) begin
            thermal_alarm_flags <= flag_events; // [R11]
        end else begin
            thermal_alarm_flags <= thermal_alarm_flags
                                   | flag_events; // [R10]
        end
    end

    // level interrupt from the unmasked flags
    assign thermal_irq = |(thermal_alarm_flags & alarm_mask); // [R17]

    // ========
    // avalon-mm slave
    // ========
    // one wait cycle per access; the request is taken when ack is high
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~bus_ack;
    assign wr_go           = avs_write & bus_ack;
    assign flags_clear     = wr_go &
                             ((avs_address == `TMTHR_FLAGS_LO) |
                              (avs_address == `TMTHR_FLAGS_HI));  // [R11]

    // read multiplexer, unmapped addresses read as zero
    always @* begin
        case (avs_address)
            `TMTHR_SAMPLE_LO: next_readdata = temp_sample_word[31:0];
            `TMTHR_SAMPLE_HI: next_readdata = temp_sample_word[63:32];
            `TMTHR_HOT_LO:    next_readdata = hot_alarm_setup[31:0];
            `TMTHR_HOT_HI:    next_readdata = hot_alarm_setup[63:32];
            `TMTHR_COLD_LO:   next_readdata = cold_alarm_setup[31:0];
            `TMTHR_COLD_HI:   next_readdata = cold_alarm_setup[63:32];
            `TMTHR_FLAGS_LO:  next_readdata = {30'h0, thermal_alarm_flags};
            `TMTHR_MASK_LO:   next_readdata = {30'h0, alarm_mask};
            `TMTHR_THROT_LO:  next_readdata = clock_throttle_setup[31:0];
            `TMTHR_THROT_HI:  next_readdata = clock_throttle_setup[63:32];
            default:          next_readdata = 32'h00000000;
        endcase
    end

    // ack handshake and registered read data
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_ack      <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else if (bus_req && !bus_ack) begin
            bus_ack <= 1'b1;
            if (avs_read) begin
                avs_readdata <= next_readdata;
            end
        end else begin
            bus_ack <= 1'b0;
        end
    end

    // setup registers; sampling word writes are ignored
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hot_alarm_setup      <= `TMTHR_SETUP_RESET;
            cold_alarm_setup     <= `TMTHR_SETUP_RESET;
            clock_throttle_setup <= `TMTHR_SETUP_RESET;
            alarm_mask           <= `TMTHR_MASK_RESET;
        end else if (wr_go) begin
            case (avs_address)
                `TMTHR_HOT_LO: begin
                    hot_alarm_setup[31:0] <= tmthr_merge(
                        hot_alarm_setup[31:0], avs_writedata,
                        avs_byteenable,
                        {2{`TMTHR_ALARM_WMASK}}); // [R5]
                end
                `TMTHR_HOT_HI: begin
                    hot_alarm_setup[63:32] <= tmthr_merge(
                        hot_alarm_setup[63:32], avs_writedata,
                        avs_byteenable,
                        {2{`TMTHR_ALARM_WMASK}}); // [R5]
                end
                `TMTHR_COLD_LO: begin
                    cold_alarm_setup[31:0] <= tmthr_merge(
                        cold_alarm_setup[31:0], avs_writedata,
                        avs_byteenable,
                        {2{`TMTHR_ALARM_WMASK}}); // [R5]
                end
                `TMTHR_COLD_HI: begin
                    cold_alarm_setup[63:32] <= tmthr_merge(
                        cold_alarm_setup[63:32], avs_writedata,
                        avs_byteenable,
                        {2{`TMTHR_ALARM_WMASK}}); // [R5]
                end
                `TMTHR_THROT_LO: begin
                    clock_throttle_setup[31:0] <= tmthr_merge(
                        clock_throttle_setup[31:0], avs_writedata,
                        avs_byteenable,
                        {2{`TMTHR_THROT_WMASK}}); // [R12]
                end
                `TMTHR_THROT_HI: begin
                    clock_throttle_setup[63:32] <= tmthr_merge(
                        clock_throttle_setup[63:32], avs_writedata,
                        avs_byteenable,
                        {2{`TMTHR_THROT_WMASK}}); // [R12]
                end
                `TMTHR_MASK_LO: begin
                    if (avs_byteenable[0]) begin
                        alarm_mask <= avs_writedata[1:0];
                    end
                end
                default: begin
                    alarm_mask <= alarm_mask;
                end
            endcase
        end
    end

endmodule

/* tmthr_sva.sv */
// assertion checker on the thermal monitor top ports
`timescale 1ns/1ps

module tmthr_sva (
    input wire        clk,
    input wire        rst,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        throttle_active,
    input wire [2:0]  throttle_ratio,
    input wire        core_clk_enable
);
    reg [7:0] hist;
    reg [2:0] last_ratio;
    reg [3:0] same;

    default clocking dcb @(posedge clk); endclocking
    default disable iff (rst);

    // ========
    // helper: enable history and run length of a steady ratio
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hist       <= 8'h00;
            last_ratio <= 3'h0;
            same       <= 4'h0;
        end else begin
            hist       <= {hist[6:0], core_clk_enable};
            last_ratio <= throttle_ratio;
            if (throttle_ratio == last_ratio && throttle_active)
                same <= (same == 4'hf) ? same : same + 4'h1;
            else
                same <= 4'h0;
        end
    end

    // ========
    // register bus handshake and throttle output checks
    AST_WAIT_IDLE: assert property (
        !(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high while idle");
    AST_WAIT_FIRST: assert property (
        (avs_read || avs_write) && !$past(avs_read) && !$past(avs_write)
        |-> avs_waitrequest)
        else $error("new request not held one cycle");
    AST_WAIT_ONE: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait cycle");
    AST_READ_HOLD: assert property (
        !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    AST_RATIO_ACTIVE: assert property (
        throttle_ratio != 3'h0 |-> throttle_active)
        else $error("ratio shown without active throttle");
    AST_FULL_SPEED: assert property (
        throttle_ratio == 3'h0 && $past(throttle_ratio) == 3'h0
        |-> core_clk_enable)
        else $error("clock gated while not throttled");
    AST_CLK_DUTY: assert property (
        same >= 4'ha && throttle_ratio != 3'h0 && throttle_ratio == last_ratio
        |-> $countones(hist) == throttle_ratio)
        else $error("enable count differs from ratio");
    AST_HALT_LOW: assert property (
        throttle_active && throttle_ratio == 3'h1 && $past(core_clk_enable)
        && same >= 4'ha |-> !core_clk_enable)
        else $error("ratio one gave two enables in a row");
endmodule

bind tmthr_top tmthr_sva u_sva (
    .clk             (clk),
    .rst             (rst),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .throttle_active (throttle_active),
    .throttle_ratio  (throttle_ratio),
    .core_clk_enable (core_clk_enable)
);

/* tmthr_sensor_model.sv */
// behavioural model of the two on-chip temperature sensors
`timescale 1ns/1ps

module tmthr_sensor_model (
    input  wire signed [9:0] temp_a,
    input  wire signed [9:0] temp_b,
    output wire [15:0]       sensor_a_raw_reading,
    output wire [15:0]       sensor_b_raw_reading
);
    // smallest raw code whose conversion lands on the given degree
    function [15:0] to_raw(input signed [9:0] c);
        integer v;
        begin
            v = ((c + 273) * 16384 + 730) / 731;
            to_raw = v[15:0];
        end
    endfunction

    assign sensor_a_raw_reading = to_raw(temp_a);
    assign sensor_b_raw_reading = to_raw(temp_b);
endmodule

/* tb_tmthr_top.sv */
// self-checking testbench for the thermal monitor
`timescale 1ns/1ps
`include "tmthr_defs.vh"

module tb_tmthr_top;
    reg               clk;
    reg               rst;
    reg        [31:0] avs_address;
    reg               avs_read;
    reg               avs_write;
    reg        [31:0] avs_writedata;
    reg        [3:0]  avs_byteenable;
    wire       [31:0] avs_readdata;
    wire              avs_waitrequest;
    wire       [15:0] raw_a;
    wire       [15:0] raw_b;
    wire              thermal_irq;
    wire              throttle_active;
    wire       [2:0]  throttle_ratio;
    wire              core_clk_enable;
    reg signed [9:0]  temp_a;
    reg signed [9:0]  temp_b;
    reg        [31:0] rd;
    reg        [31:0] a_v;
    integer           fail_count;
    integer           comparisons;
    integer           cycles;
    integer           k;

    tmthr_top u_dut (
        .clk                  (clk),
        .rst                  (rst),
        .avs_address          (avs_address),
        .avs_read             (avs_read),
        .avs_write            (avs_write),
        .avs_writedata        (avs_writedata),
        .avs_byteenable       (avs_byteenable),
        .avs_readdata         (avs_readdata),
        .avs_waitrequest      (avs_waitrequest),
        .sensor_a_raw_reading (raw_a),
        .sensor_b_raw_reading (raw_b),
        .thermal_irq          (thermal_irq),
        .throttle_active      (throttle_active),
        .throttle_ratio       (throttle_ratio),
        .core_clk_enable      (core_clk_enable)
    );

    tmthr_sensor_model u_sensors (
        .temp_a               (temp_a),
        .temp_b               (temp_b),
        .sensor_a_raw_reading (raw_a),
        .sensor_b_raw_reading (raw_b)
    );

    // ========
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            end_sim;
        end
    end

    // ========
    // shared tasks
    task end_sim;
        begin
            $display("fails %0d compares %0d", fail_count, comparisons);
            if (fail_count == 0 && comparisons > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp, input string what);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
            end
        end
    endtask

    // one avalon access, held until waitrequest is seen low
    task bus(input wr, input [31:0] a, input [31:0] d, input [3:0] be);
        integer n;
        begin
            n = 0;
            avs_address    <= a;
            avs_writedata  <= d;
            avs_byteenable <= be;
            avs_read       <= !wr;
            avs_write      <= wr;
            @(posedge clk);
            while (avs_waitrequest !== 1'b0 && n < 20) begin
                @(posedge clk);
                n = n + 1;
            end
            chk(n < 20, 32'h1, "bus wait");
            rd = avs_readdata;
            avs_read  <= 1'b0;
            avs_write <= 1'b0;
            @(posedge clk);
        end
    endtask

    task wr(input [31:0] a, input [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task rdchk(input [31:0] a, input [31:0] exp, input string what);
        begin
            bus(1'b0, a, 32'h0, 4'hf);
            chk(rd, exp, what);
        end
    endtask

    // new sensor temperatures, then wait out the synchroniser
    task heat(input signed [9:0] ta, input signed [9:0] tb);
        begin
            temp_a <= ta;
            temp_b <= tb;
            repeat (8) @(posedge clk);
        end
    endtask

    task duty(input [31:0] exp);
        reg [31:0] n;
        integer    i;
        begin
            n = 32'h0;
            repeat (4) @(posedge clk);
            for (i = 0; i < 8; i = i + 1) begin
                @(posedge clk);
                n = n + core_clk_enable;
            end
            chk(n, exp, "duty");
        end
    endtask

    // ========
    // scenarios
    task t_reset;
        begin
            chk(thermal_irq, 32'h0, "irq");
            chk({throttle_active, throttle_ratio}, 32'h0, "thr");
            chk(core_clk_enable, 32'h1, "clken");
            rdchk(`TMTHR_MASK_LO, 32'h3, "mask");
            rdchk(`TMTHR_FLAGS_LO, 32'h0, "flags");
            rdchk(`TMTHR_HOT_LO, 32'h0, "hot");
            rdchk(`TMTHR_THROT_HI, 32'h0, "throt");
        end
    endtask

    task t_regs;
        begin
            for (k = 0; k < 6; k = k + 1) begin
                a_v = (k < 4) ? `TMTHR_HOT_LO + 4 * k
                              : `TMTHR_THROT_LO + 4 * (k - 4);
                wr(a_v, 32'hffffffff);
                rdchk(a_v, (k < 4) ? 32'h0dff0dff : 32'h7dff7dff, "lane");
                wr(a_v, 32'h0);
            end
            wr(`TMTHR_MASK_HI, 32'hffffffff);
            rdchk(`TMTHR_MASK_HI, 32'h0, "mask hi");
            rdchk(`TMTHR_FLAGS_HI, 32'h0, "flags hi");
            wr(32'h3ff0148c, 32'hffffffff);
            rdchk(32'h3ff0148c, 32'h0, "unmapped");
        end
    endtask

    task t_sample;
        begin
            heat(130, 20);
            rdchk(`TMTHR_SAMPLE_LO, 32'h01000000, "over a");
            rdchk(`TMTHR_SAMPLE_HI, {raw_b, raw_a}, "raw");
            heat(20, 126);
            wr(`TMTHR_SAMPLE_LO, 32'hffffffff);
            rdchk(`TMTHR_SAMPLE_LO, 32'h02000000, "over b");
            rdchk(`TMTHR_SAMPLE_HI, {raw_b, raw_a}, "raw b");
            heat(125, 125);
            rdchk(`TMTHR_SAMPLE_LO, 32'h0, "limit");
        end
    endtask

    task t_hot;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                a_v = (k < 2) ? `TMTHR_HOT_LO : `TMTHR_HOT_HI;
                heat(60, 50);
                wr(a_v, 32'h0532 << (16 * (k % 2)));
                wr(`TMTHR_FLAGS_LO, 32'h0);
                rdchk(`TMTHR_FLAGS_LO, 32'h0, "hot eq");
                heat(60, 51);
                chk(thermal_irq, 32'h1, "hot irq");
                rdchk(`TMTHR_FLAGS_LO, 32'h1, "hot flag");
                heat(60, 40);
                bus(1'b1, `TMTHR_FLAGS_HI, 32'h5a5a5a5a, 4'h0);
                rdchk(`TMTHR_FLAGS_LO, 32'h0, "clear");
                chk(thermal_irq, 32'h0, "irq clr");
                wr(a_v, 32'h0);
            end
            wr(`TMTHR_HOT_LO, 32'h0432);
            heat(25, 51);
            rdchk(`TMTHR_FLAGS_LO, 32'h0, "disabled");
            wr(`TMTHR_HOT_LO, 32'h0532);
            heat(25, 51);
            wr(`TMTHR_MASK_LO, 32'h0);
            chk(thermal_irq, 32'h0, "masked");
            rdchk(`TMTHR_FLAGS_LO, 32'h1, "sticky");
            wr(`TMTHR_MASK_LO, 32'h3);
            chk(thermal_irq, 32'h1, "unmask");
            wr(`TMTHR_HOT_LO, 32'h0);
            wr(`TMTHR_FLAGS_LO, 32'h0);
        end
    endtask

    task t_cold;
        begin
            heat(-10, 25);
            wr(`TMTHR_COLD_LO, 32'h01f6);
            wr(`TMTHR_FLAGS_LO, 32'h0);
            rdchk(`TMTHR_FLAGS_LO, 32'h0, "cold eq");
            heat(-11, 25);
            rdchk(`TMTHR_FLAGS_LO, 32'h2, "cold flag");
            chk(thermal_irq, 32'h1, "cold irq");
            heat(25, 25);
            wr(`TMTHR_COLD_LO, 32'h0);
            wr(`TMTHR_FLAGS_LO, 32'h0);
            rdchk(`TMTHR_FLAGS_LO, 32'h0, "cold clr");
        end
    endtask

    task t_throt;
        begin
            wr(`TMTHR_THROT_LO, 32'h3132);
            wr(`TMTHR_THROT_HI, 32'h5128);
            heat(60, 25);
            chk({throttle_active, throttle_ratio}, 32'hb, "prio");
            duty(32'h3);
            wr(`TMTHR_THROT_LO, 32'h0);
            duty(32'h5);
            chk({throttle_active, throttle_ratio}, 32'hd, "next");
            heat(40, 25);
            chk({throttle_active, throttle_ratio}, 32'h0, "off");
            duty(32'h8);
            wr(`TMTHR_THROT_HI, 32'h0);
        end
    endtask

    // ========
    // main sequence
    initial begin
        rst            = 1'b1;
        avs_address    = 32'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hf;
        temp_a         = 10'sd25;
        temp_b         = 10'sd25;
        fail_count     = 0;
        comparisons    = 0;
        cycles         = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_regs;
        t_sample;
        t_hot;
        t_cold;
        t_throt;
        end_sim;
    end
endmodule
